// >>> bench/tpc_props.sv
/*
 port assertions for the timer/pwm and comparator control block.
 assumes a bind from the bench top and apb byte addresses 0x60-0x7C.
*/
`timescale 1ns/100ps
module tpc_props
  import tpc_pkg::*;
#(
  parameter logic TIMER_PIN_BUILD_OPTION = 1'h0
)
(
  // watched ports
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        cmp_raw,
  input wire logic        cmp_enable,
  input wire logic [2:0]  cmp_minus_sel,
  input wire logic        cmp_plus_sel,
  input wire logic        cmp_range_hi,
  input wire logic        cmp_range_lo,
  input wire logic [3:0]  cmp_level_sel,
  input wire logic        port_a_bit0_oe,
  input wire logic [3:0]  timer_pin_oe,
  input wire logic        cmp_wake
);
  // ------
  // shadows of the output routing and wake enable fields
  // ------
  logic       wr;
  logic       rd;
  logic [1:0] out_q;
  logic       wake_q;
  logic [3:0] oe_exp;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign oe_exp = (out_q == 2'h0) ? 4'h0 : (out_q == 2'h1) ? (TIMER_PIN_BUILD_OPTION ? 4'h2 : 4'h1) :
                  (out_q == 2'h2) ? 4'h4 : 4'h8;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) out_q <= 2'h0;
    else if (wr && paddr == 12'h070) out_q <= pwdata[3:2];
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) wake_q <= 1'h0;
    else if (wr && paddr == 12'h064) wake_q <= pwdata[6];
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!nrst);
  AST_CMP_OE: assert property (wr && paddr == 12'h064 |=> port_a_bit0_oe == $past(pwdata[7]))
    else $error("comparator pin enable does not follow its write");
  AST_INPUTS: assert property (wr && paddr == 12'h060 |=>
    cmp_minus_sel == $past(pwdata[3:1]) && cmp_plus_sel == $past(pwdata[0]))
    else $error("comparator input selects do not follow their write");
  AST_RANGE: assert property (wr && paddr == 12'h064 |=>
    {cmp_range_hi, cmp_range_lo, cmp_level_sel} == $past(pwdata[5:0]))
    else $error("range or level select does not follow its write");
  AST_RESULT: assert property (rd && paddr == 12'h060 && cmp_enable && $past(cmp_enable, 3) &&
    $stable(cmp_raw) && $past(cmp_raw) == $past(cmp_raw, 2) |-> prdata[6] == cmp_raw)
    else $error("result bit differs from settled comparator level");
  AST_WAKE: assert property (!wake_q && !$past(wake_q) |-> !cmp_wake)
    else $error("wake pulse while wake is disabled");
  AST_PINS: assert property ($stable(out_q) |-> timer_pin_oe == oe_exp)
    else $error("timer pin enables do not match output routing");
  AST_UPPER: assert property (rd |-> prdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  AST_WO: assert property (rd && (paddr == 12'h064 || paddr == 12'h078) |-> prdata == 32'h0)
    else $error("write-only register reads nonzero");
  cover property (wake_q && cmp_wake);
  cover property (rd && paddr == 12'h074);
  cover property (port_a_bit0_oe && timer_pin_oe == 4'h8);
endmodule

// >>> bench/tpc_tb_top.sv
/*
 self-checking bench: apb register traffic, clock sources, pins, wake.
 assumes the design files and tpc_props.sv are compiled before it.
*/
`timescale 1ns/100ps
module timer_pwm_with_comparator_ctrl_tb_top;
  import tpc_pkg::*;
  logic        clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, cmp_raw = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        fast_internal_oscillator = 1'h0, fast_internal_oscillator_x2 = 1'h0;
  logic        external_oscillator = 1'h0, slow_internal_oscillator = 1'h0, port_a_bit0_in = 1'h0;
  logic        pready, pslverr, cmp_enable, cmp_plus_sel, cmp_range_hi, cmp_range_lo, cmp_wake;
  logic [2:0]  cmp_minus_sel;
  logic [3:0]  cmp_level_sel, timer_pin_oe;
  logic        port_a_bit0_out, port_a_bit0_oe, port_b_bit2_out, port_b_bit0_out, port_a_bit3_out, port_b_bit4_out;
  logic [32:0] exp_q[$];
  logic [11:0] adr[6] = '{12'h060, 12'h064, 12'h070, 12'h074, 12'h078, 12'h07C};
  logic [3:0]  src[8] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9};
  logic [7:0]  v;
  int          n_fail = 0, checks_done = 0, n_wake = 0, k, n, d, dv;
  tpc_timer_cmp uut (.*);
  always #12.5 clk = ~clk;
  always @(posedge clk) if (cmp_wake === 1'h1) n_wake++;
  always @(posedge clk) if (psel && penable && !pwrite && pready) chk(exp_q.pop_front(), {pslverr, prdata});
  // ------
  // tasks
  // ------
  task automatic chk(input logic [32:0] e, input logic [32:0] g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int t;
    t = 0;
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, wd};
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1 && t < 20)
    begin
      @(posedge clk);
      t++;
    end
    if (t == 20)
    begin
      n_fail++;
      end_sim();
    end
    {psel, penable} <= 2'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    exp_q.push_back({err, e});
    apb(1'h0, a, 32'h0);
  endtask
  // one source event: a tick pulse, or a full rise and fall of a level input
  task automatic ev(input logic [3:0] s);
    case (s)
      4'h3: external_oscillator <= 1'h1;
      4'h4: slow_internal_oscillator <= 1'h1;
      4'h5, 4'h7: cmp_raw <= 1'h1;
      4'h8, 4'h9: port_a_bit0_in <= 1'h1;
      default: fast_internal_oscillator <= 1'h1;
    endcase
    @(posedge clk);
    {fast_internal_oscillator, external_oscillator, slow_internal_oscillator} <= 3'h0;
    repeat (4) @(posedge clk);
    {cmp_raw, port_a_bit0_in} <= 2'h0;
    repeat (4) @(posedge clk);
  endtask
  initial
  begin
    k = $urandom(89688);
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    foreach (adr[i]) rd(adr[i], 32'h0, 1'h0);
    rd(12'h7FC, 32'h0, 1'h1);
    $display("test reset done");
    for (k = 0; k < 6; k++)
    begin
      v = {2'h3, 1'h0, 1'($urandom), 3'(k), 1'($urandom)};
      cmp_raw <= k[0];
      apb(1'h1, 12'h060, {24'h0, v});
      repeat (3) @(posedge clk);
      rd(12'h060, {24'h0, v[7], k[0], v[5:0]}, 1'h0);
      chk({32'h0, k[0] ^ v[4]}, {32'h0, port_a_bit0_out});
    end
    r = $urandom;
    apb(1'h1, 12'h064, r);
    rd(12'h064, 32'h0, 1'h0);
    apb(1'h1, 12'h078, r);
    rd(12'h078, 32'h0, 1'h0);
    $display("test comparator registers done");
    for (k = 0; k < 4; k++)
    begin
      v = {4'h0, 2'(k), 2'(k)};
      apb(1'h1, 12'h070, {24'h0, v});
      rd(12'h070, {24'h0, v}, 1'h0);
      if (k > 1) chk({32'h0, ~k[0]}, {32'h0, k[0] ? port_b_bit4_out : port_a_bit3_out});
    end
    apb(1'h1, 12'h070, 32'h0);
    cmp_raw <= 1'h0;
    apb(1'h1, 12'h060, 32'h80);
    foreach (src[i])
    begin
      d = $urandom_range(0, 2);
      n = $urandom_range(1, 3);
      v = $urandom;
      dv = (i % 2 == 1 ? 4 : 1) * (d + 1);
      apb(1'h1, 12'h078, {24'h0, 1'h0, 2'(i % 2), 5'(d)});
      apb(1'h1, 12'h074, {24'h0, v});
      apb(1'h1, 12'h070, {24'h0, src[i], 4'h0});
      repeat (n * dv) ev(src[i]);
      apb(1'h1, 12'h070, 32'h0);
      v = v + (src[i] == 4'h0 ? 8'h0 : 8'(n));
      rd(12'h074, {24'h0, v}, 1'h0);
    end
    $display("test clock sources done");
    cmp_raw <= 1'h0;
    apb(1'h1, 12'h060, 32'hA0);
    apb(1'h1, 12'h070, 32'h10);
    repeat (20) @(posedge clk);
    apb(1'h1, 12'h070, 32'h0);
    cmp_raw <= 1'h1;
    repeat (8) @(posedge clk);
    chk(33'h0, {32'h0, port_a_bit0_out});
    apb(1'h1, 12'h070, 32'h10);
    repeat (20) @(posedge clk);
    chk(33'h1, {32'h0, port_a_bit0_out});
    cmp_raw <= 1'h0;
    apb(1'h1, 12'h070, 32'h0);
    apb(1'h1, 12'h060, 32'h80);
    $display("test sampled result done");
    apb(1'h1, 12'h064, 32'h40);
    n_wake = 0;
    repeat (3) ev(4'h5);
    chk(33'h6, 33'(n_wake));
    apb(1'h1, 12'h064, 32'h0);
    n_wake = 0;
    repeat (2) ev(4'h5);
    chk(33'h0, 33'(n_wake));
    $display("test wake done");
    end_sim();
  end
endmodule
bind tpc_timer_cmp tpc_props #(.TIMER_PIN_BUILD_OPTION(TIMER_PIN_BUILD_OPTION)) u_props (.*);

// >>> design/tpc_cfg.svh
/*
 timer/pwm and comparator control: register offsets, field positions, resets.
 assumes inclusion by the package and the single design module.
*/
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH
// ----------------------------------------
// register indices (byte address = 4 x index)
// ----------------------------------------
`define TPC_IDX_CMP_CTRL   8'h18
`define TPC_IDX_CMP_SEL    8'h19
`define TPC_IDX_TMR_CTRL   8'h1C
`define TPC_IDX_TMR_COUNT  8'h1D
`define TPC_IDX_TMR_DIV    8'h1E
`define TPC_IDX_TMR_BOUND  8'h1F
// ----------------------------------------
// field positions
// ----------------------------------------
`define TPC_CC_ENABLE      7
`define TPC_CC_RESULT      6
`define TPC_CC_SAMPLE      5
`define TPC_CC_INVERT      4
`define TPC_CC_MINUS_HI    3
`define TPC_CC_MINUS_LO    1
`define TPC_CC_PLUS        0
`define TPC_CS_OUT_EN      7
`define TPC_CS_WAKE_EN     6
`define TPC_CS_RANGE_HI    5
`define TPC_CS_RANGE_LO    4
`define TPC_TC_SRC_HI      7
`define TPC_TC_SRC_LO      4
`define TPC_TC_OUT_HI      3
`define TPC_TC_OUT_LO      2
`define TPC_TC_MODE        1
`define TPC_TC_INVERT      0
`define TPC_TD_RES         7
`define TPC_TD_PRE_HI      6
`define TPC_TD_PRE_LO      5
`define TPC_TD_SCALE_HI    4
// ----------------------------------------
// reset values
// ----------------------------------------
`define TPC_RST_BYTE       8'h00
`define TPC_RST_BOUND      8'hFF
`endif

// >>> design/tpc_pkg.sv
/*
 types for the timer/pwm and comparator control block.
 assumes tpc_cfg.svh is on the include path.
*/
package tpc_pkg;
  `include "tpc_cfg.svh"
  typedef enum logic [3:0]
  {
    TPC_SRC_STOP     = 4'h0,
    TPC_SRC_SYS      = 4'h1,
    TPC_SRC_FAST     = 4'h2,
    TPC_SRC_EXT      = 4'h3,
    TPC_SRC_SLOW     = 4'h4,
    TPC_SRC_CMP      = 4'h5,
    TPC_SRC_CMP_ALT  = 4'h7,
    TPC_SRC_PA0_RISE = 4'h8,
    TPC_SRC_PA0_FALL = 4'h9
  } tpc_src_t;
  typedef enum logic [1:0]
  {
    TPC_OUT_OFF  = 2'h0,
    TPC_OUT_PB2  = 2'h1,
    TPC_OUT_PA3  = 2'h2,
    TPC_OUT_PB4  = 2'h3
  } tpc_out_t;
endpackage

// >>> design/tpc_timer_cmp.sv
/*
 8-bit timer/pwm unit with the digital path of a voltage comparator, apb slave.
 assumes oscillator and pin inputs already synchronous to clk; analog core outside.
*/
`timescale 1ns/100ps
`include "tpc_cfg.svh"
// Contract
// - clock source codes 0..4: stopped, system, fast osc, external osc, slow osc
// - code 0101 clocks the timer from the comparator output
// - codes 1000/1001 count rising/falling edges of port a bit 0
// - output field routes waveform to none, pb2/pb0, pa3, pb4
// - control bit 1: period mode when clear, pwm mode when set
// - control bit 0 inverts the timer waveform polarity
// - counter is 8-bit, readable and writable, resets to zero
// - divider bit 7 selects 8-bit or 6/7-bit pwm resolution
// - prescaler bits 6-5 divide by 1, 4, 16, 64; reset 00
// - bits 4-0 are a 5-bit scalar further dividing the clock
// - bit 6 is read-only result: 1 when plus exceeds minus
// - bit 5 samples the comparator output with the timer clock
// - bit 4 inverts the comparator output polarity
// - bits 3-1 pick the minus input; 11x reserved
// - bit 0 picks plus input: resistor reference or pa4
// - write-only enable routes comparator output to port a bit 0
// - with wake enable set, any result change wakes the device
// - selection bits 5,4 pick ranges, 3-0 the reference tap
module tpc_timer_cmp
  import tpc_pkg::*;
#(
  parameter logic PWM_WIDTH_BUILD_OPTION   = 1'b0,
  parameter logic FAST_CLOCK_DOUBLE_OPTION = 1'b0,
  parameter logic TIMER_PIN_BUILD_OPTION   = 1'b0
)
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // clock source ticks, one cycle each; port a bit 0 is a level input
  input  wire logic        fast_internal_oscillator,
  input  wire logic        fast_internal_oscillator_x2,
  input  wire logic        external_oscillator,
  input  wire logic        slow_internal_oscillator,
  input  wire logic        port_a_bit0_in,
  // analog comparator core
  input  wire logic        cmp_raw,
  output logic             cmp_enable,
  output logic      [2:0]  cmp_minus_sel,
  output logic             cmp_plus_sel,
  output logic             cmp_range_hi,
  output logic             cmp_range_lo,
  output logic      [3:0]  cmp_level_sel,
  // pins and wake
  output logic             port_a_bit0_out,
  output logic             port_a_bit0_oe,
  output logic             port_b_bit2_out,
  output logic             port_b_bit0_out,
  output logic             port_a_bit3_out,
  output logic             port_b_bit4_out,
  output logic      [3:0]  timer_pin_oe,
  output logic             cmp_wake
);
  import tpc_pkg::*;
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] cmp_ctrl_q;
  logic [7:0] cmp_sel_q;
  logic [7:0] tmr_ctrl_q;
  logic [7:0] tmr_count_q;
  logic [7:0] tmr_div_q;
  logic [7:0] tmr_bound_q;
  logic [9:0] reg_idx;
  logic       wr_en;
  logic       mapped;
  assign reg_idx = paddr[11:2];
  assign wr_en   = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign mapped  = (reg_idx == {2'h0, `TPC_IDX_CMP_CTRL}) | (reg_idx == {2'h0, `TPC_IDX_CMP_SEL})
                 | (reg_idx == {2'h0, `TPC_IDX_TMR_CTRL}) | (reg_idx == {2'h0, `TPC_IDX_TMR_COUNT})
                 | (reg_idx == {2'h0, `TPC_IDX_TMR_DIV}) | (reg_idx == {2'h0, `TPC_IDX_TMR_BOUND});
  assign pslverr = psel & penable & ~mapped;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cmp_ctrl_q  <= `TPC_RST_BYTE;
      cmp_sel_q   <= `TPC_RST_BYTE;
      tmr_ctrl_q  <= `TPC_RST_BYTE;
      tmr_div_q   <= `TPC_RST_BYTE;
      tmr_bound_q <= `TPC_RST_BOUND;
    end
    // unmapped aliases above index 0xFF must not reach the byte registers
    else if (wr_en && mapped)
    begin
      case (reg_idx[7:0])
        `TPC_IDX_CMP_CTRL:  cmp_ctrl_q  <= {pwdata[7], 1'b0, pwdata[5:0]};
        `TPC_IDX_CMP_SEL:   cmp_sel_q   <= pwdata[7:0];
        `TPC_IDX_TMR_CTRL:  tmr_ctrl_q  <= pwdata[7:0];
        `TPC_IDX_TMR_DIV:   tmr_div_q   <= pwdata[7:0];
        `TPC_IDX_TMR_BOUND: tmr_bound_q <= pwdata[7:0];
        default:            ;
      endcase
    end
  end
  // ----------------------------------------
  // comparator path
  // ----------------------------------------
  logic cmp_s1_q;
  logic cmp_s2_q;
  logic cmp_prev_q;
  logic cmp_hold_q;
  logic cmp_out;
  logic tick;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end
    else
    begin
      cmp_s1_q <= cmp_raw & cmp_ctrl_q[`TPC_CC_ENABLE];
      cmp_s2_q <= cmp_s1_q;
    end
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cmp_hold_q <= 1'b0;
    else if (tick)
      cmp_hold_q <= cmp_s2_q;
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cmp_prev_q <= 1'b0;
    else
      cmp_prev_q <= cmp_s2_q;
  end
  // reserved minus codes are kept but treated as the default input by the core
  assign cmp_out = (cmp_ctrl_q[`TPC_CC_SAMPLE] ? cmp_hold_q : cmp_s2_q)
                 ^ cmp_ctrl_q[`TPC_CC_INVERT];
  assign cmp_wake      = cmp_sel_q[`TPC_CS_WAKE_EN] & (cmp_s2_q ^ cmp_prev_q);
  assign cmp_enable    = cmp_ctrl_q[`TPC_CC_ENABLE];
  assign cmp_minus_sel = cmp_ctrl_q[`TPC_CC_MINUS_HI:`TPC_CC_MINUS_LO];
  assign cmp_plus_sel  = cmp_ctrl_q[`TPC_CC_PLUS];
  assign cmp_range_hi  = cmp_sel_q[`TPC_CS_RANGE_HI];
  assign cmp_range_lo  = cmp_sel_q[`TPC_CS_RANGE_LO];
  assign cmp_level_sel = cmp_sel_q[3:0];
  assign port_a_bit0_out = cmp_out;
  assign port_a_bit0_oe  = cmp_sel_q[`TPC_CS_OUT_EN];
  // ----------------------------------------
  // clock source and division
  // ----------------------------------------
  logic pa0_s1_q;
  logic pa0_s2_q;
  logic pa0_prev_q;
  logic cmpo_prev_q;
  logic src_tick;
  logic [5:0] pre_q;
  logic [4:0] scale_q;
  logic pre_done;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pa0_s1_q    <= 1'b0;
      pa0_s2_q    <= 1'b0;
      pa0_prev_q  <= 1'b0;
      cmpo_prev_q <= 1'b0;
    end
    else
    begin
      pa0_s1_q    <= port_a_bit0_in;
      pa0_s2_q    <= pa0_s1_q;
      pa0_prev_q  <= pa0_s2_q;
      cmpo_prev_q <= cmp_out;
    end
  end
  always_comb
  begin
    case (tmr_ctrl_q[`TPC_TC_SRC_HI:`TPC_TC_SRC_LO])
      TPC_SRC_STOP:     src_tick = 1'b0;
      TPC_SRC_SYS:      src_tick = 1'b1;
      TPC_SRC_FAST:     src_tick = FAST_CLOCK_DOUBLE_OPTION ? fast_internal_oscillator_x2
                                                            : fast_internal_oscillator;
      TPC_SRC_EXT:      src_tick = external_oscillator;
      TPC_SRC_SLOW:     src_tick = slow_internal_oscillator;
      TPC_SRC_CMP,
      TPC_SRC_CMP_ALT:  src_tick = cmp_out & ~cmpo_prev_q;
      TPC_SRC_PA0_RISE: src_tick = pa0_s2_q & ~pa0_prev_q;
      TPC_SRC_PA0_FALL: src_tick = ~pa0_s2_q & pa0_prev_q;
      default:          src_tick = 1'b0;
    endcase
  end
  // prescale limit: 0, 3, 15, 63
  logic [5:0] pre_lim;
  always_comb
  begin
    case (tmr_div_q[`TPC_TD_PRE_HI:`TPC_TD_PRE_LO])
      2'h0:    pre_lim = 6'h00;
      2'h1:    pre_lim = 6'h03;
      2'h2:    pre_lim = 6'h0F;
      default: pre_lim = 6'h3F;
    endcase
  end
  assign pre_done = src_tick & (pre_q >= pre_lim);
  assign tick     = pre_done & (scale_q >= tmr_div_q[`TPC_TD_SCALE_HI:0]);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pre_q   <= 6'h00;
      scale_q <= 5'h00;
    end
    else if (src_tick)
    begin
      pre_q <= pre_done ? 6'h00 : pre_q + 6'h01;
      if (pre_done)
        scale_q <= tick ? 5'h00 : scale_q + 5'h01;
    end
  end
  // ----------------------------------------
  // counter and waveform
  // ----------------------------------------
  logic [7:0] top;
  logic       wave_q;
  logic       wave;
  assign top = !tmr_div_q[`TPC_TD_RES] ? 8'hFF : (PWM_WIDTH_BUILD_OPTION ? 8'h7F : 8'h3F);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      tmr_count_q <= `TPC_RST_BYTE;
    else if (wr_en && reg_idx == {2'h0, `TPC_IDX_TMR_COUNT})
      tmr_count_q <= pwdata[7:0];
    else if (tick)
    begin
      if (tmr_ctrl_q[`TPC_TC_MODE])
        tmr_count_q <= (tmr_count_q >= top) ? 8'h00 : tmr_count_q + 8'h01;
      else
        tmr_count_q <= (tmr_count_q == tmr_bound_q) ? 8'h00 : tmr_count_q + 8'h01;
    end
  end
  // period mode toggles on bound match; pwm is high while count is below bound
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      wave_q <= 1'b0;
    else if (!tmr_ctrl_q[`TPC_TC_MODE])
    begin
      if (tick && tmr_count_q == tmr_bound_q)
        wave_q <= ~wave_q;
    end
    else
      wave_q <= (tmr_count_q & top) < (tmr_bound_q & top);
  end
  assign wave = wave_q ^ tmr_ctrl_q[`TPC_TC_INVERT];
  always_comb
  begin
    timer_pin_oe = 4'h0;
    case (tmr_ctrl_q[`TPC_TC_OUT_HI:`TPC_TC_OUT_LO])
      TPC_OUT_PB2: timer_pin_oe = TIMER_PIN_BUILD_OPTION ? 4'h2 : 4'h1;
      TPC_OUT_PA3: timer_pin_oe = 4'h4;
      TPC_OUT_PB4: timer_pin_oe = 4'h8;
      default:     timer_pin_oe = 4'h0;
    endcase
  end
  assign port_b_bit2_out = wave;
  assign port_b_bit0_out = wave;
  assign port_a_bit3_out = wave;
  assign port_b_bit4_out = wave;
  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb
  begin
    prdata = 32'h0000_0000;
    case (reg_idx[7:0])
      `TPC_IDX_CMP_CTRL:  prdata[7:0] = {cmp_ctrl_q[7], cmp_s2_q, cmp_ctrl_q[5:0]};
      `TPC_IDX_TMR_CTRL:  prdata[7:0] = tmr_ctrl_q;
      `TPC_IDX_TMR_COUNT: prdata[7:0] = tmr_count_q;
      default:            prdata = 32'h0000_0000;
    endcase
    if (reg_idx[9:8] != 2'h0)
      prdata = 32'h0000_0000;
  end
endmodule
